// ### hw/pstb_defs.svh
`ifndef PSTB_DEFS_SVH
`define PSTB_DEFS_SVH
// timing and sizes
`define PSTB_CLK_NS        100
`define PSTB_TICK_NS       5000000
`define PSTB_TICK_MS       5
`define PSTB_CS_MS         10
`define PSTB_NEAR_MS       20
`define PSTB_FAR_MS        200
`define PSTB_REC_DEPTH     12
`define PSTB_VAL_W         16
`define PSTB_OP_W          24
// arithmetic
`define PSTB_PCT           32'h0000_0064
`define PSTB_HYST_PCT      32'h0000_0067
`define PSTB_Q             12
`define PSTB_A_UNIT        16'h0064
`define PSTB_A_MAX         16'h0019
// register byte addresses
`define PSTB_A_CTRL        8'h00
`define PSTB_A_USET        8'h04
`define PSTB_A_DT          8'h08
`define PSTB_A_REL         8'h0C
`define PSTB_A_INVERSE_DELAY_MODE        8'h10
`define PSTB_A_STAT        8'h14
`define PSTB_A_CNT_ST      8'h18
`define PSTB_A_CNT_TR      8'h1C
`define PSTB_A_CNT_BL      8'h20
`define PSTB_A_CMD         8'h24
`define PSTB_A_RSEL        8'h28
`define PSTB_A_REC_T       8'h2C
`define PSTB_A_REC_E       8'h30
`define PSTB_A_REC_V       8'h34
`define PSTB_A_REC_F       8'h38
`define PSTB_A_REC_R       8'h3C
`define PSTB_A_REC_P       8'h40
// control fields
`define PSTB_CTRL_DTYPE    0
`define PSTB_CTRL_DREL     1
`define PSTB_CTRL_TRST     2
`define PSTB_CTRL_CONT     3
`define PSTB_CTRL_MASK     4
`define PSTB_CMD_CLR       0
// reset values
`define PSTB_RST_CTRL      32'h0000_03F6
`define PSTB_RST_USET      32'h0000_07D0
`define PSTB_RST_DT        32'h0000_0008
`define PSTB_RST_REL       32'h0000_000C
`define PSTB_RST_INVERSE_DELAY_MODE      32'h0064_0005
`endif

// ### hw/pstb_pkg.sv
package pstb_pkg;
  typedef enum logic [1:0] {
    PSTB_C_IDLE  = 2'b00,
    PSTB_C_RATIO = 2'b01,
    PSTB_C_POW   = 2'b10,
    PSTB_C_TIME  = 2'b11
  } pstb_calc_e;
  typedef enum logic [2:0] {
    PSTB_EV_START_ON  = 3'b000,
    PSTB_EV_START_OFF = 3'b001,
    PSTB_EV_TRIP_ON   = 3'b010,
    PSTB_EV_TRIP_OFF  = 3'b011,
    PSTB_EV_BLOCK_ON  = 3'b100,
    PSTB_EV_BLOCK_OFF = 3'b101
  } pstb_evt_e;
endpackage

// ### hw/pstb_stage.sv
`timescale 1ns/10ps
`include "pstb_defs.svh"
// How it works
// RULE_01 - sample blocking input once per tick
// RULE_02 - unblocked pick-up raises start, begins timing
// RULE_03 - blocked pick-up raises blocked, no timing
// RULE_04 - blocking source must lead trip by 5ms
// RULE_05 - instant mode trips with start
// RULE_06 - fixed delay trips after configured ticks
// RULE_07 - inverse delay k over (ratio-1)^a
// RULE_08 - delay-type select, defaults to fixed
// RULE_09 - fixed delay in 5ms ticks, zero instant
// RULE_10 - inverse k and a defaults
// RULE_11 - release delay holds start, default 60ms
// RULE_12 - delayed release optional, else drop immediately
// RULE_13 - timer clears after release or immediately
// RULE_14 - optionally keep counting during release
// RULE_15 - no trip during release without re-pickup
// RULE_16 - masked on/off events with time stamp
// RULE_17 - clearable start, trip, blocked counters
// RULE_18 - twelve-entry fault record ring
// RULE_19 - record written on asserting edges only
// RULE_20 - record holds time, values, remaining, group
// RULE_21 - pick below setting, release at 103%
// RULE_22 - low current inhibits trip when nonzero
// RULE_23 - timers advance in 5ms ticks
module pstb_stage #(
  parameter int unsigned TICK_CYCLES = `PSTB_TICK_NS / `PSTB_CLK_NS
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic [7:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire logic                       block_i,
  input  wire logic [`PSTB_VAL_W-1:0]     meas_u3h_i,
  input  wire logic [`PSTB_VAL_W-1:0]     ipos_i,
  input  wire logic [2:0]                 setting_group_i,
  input  wire logic [31:0]                timestamp_i,
  output logic                            start_o,
  output logic                            trip_o,
  output logic                            blocked_o,
  output logic                            event_valid_o,
  output pstb_pkg::pstb_evt_e             event_code_o,
  output logic      [31:0]                event_time_o
);
  import pstb_pkg::*;

  localparam int unsigned HDEPTH = `PSTB_FAR_MS / `PSTB_TICK_MS;
  localparam int unsigned HNEAR  = `PSTB_NEAR_MS / `PSTB_TICK_MS;
  localparam int unsigned TPCS   = `PSTB_CS_MS / `PSTB_TICK_MS;
  localparam int unsigned OPW    = `PSTB_OP_W;

  function automatic logic [2:0] low_idx(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] div_step(input logic [31:0] rm, input logic [31:0] nm, input logic [31:0] dn);
    logic [32:0] t;
    t = {rm, nm[31]};
    if (t >= {1'b0, dn}) begin
      return {32'(t - {1'b0, dn}), nm[30:0], 1'b1};
    end
    return {t[31:0], nm[30:0], 1'b0};
  endfunction

  function automatic logic [15:0] cnt_upd(input logic [15:0] c, input logic inc, input logic clr);
    // an occurrence in the clearing cycle is kept
    if (inc) begin
      return clr ? 16'h0001 : 16'(c + 16'h0001);
    end
    return clr ? 16'h0000 : c;
  endfunction

  // processing tick
  logic [31:0] tick_cnt_reg;
  wire         tick_w = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  wire  [31:0] tick_cnt_next = tick_w ? 32'h0 : 32'(tick_cnt_reg + 32'h1);

  // bus slave, one wait cycle per access
  logic [31:0] ctrl_reg, uset_reg, dt_reg, rel_reg, inverse_delay_mode_reg, rsel_reg;
  logic        ack_reg;
  wire         req_w  = avs_read_i | avs_write_i;
  wire         wr_w   = avs_write_i & ack_reg;
  wire         wr_ctl = wr_w & (avs_address_i == `PSTB_A_CTRL);
  wire         wr_us  = wr_w & (avs_address_i == `PSTB_A_USET);
  wire         wr_dt  = wr_w & (avs_address_i == `PSTB_A_DT);
  wire         wr_rel = wr_w & (avs_address_i == `PSTB_A_REL);
  wire         wr_id  = wr_w & (avs_address_i == `PSTB_A_INVERSE_DELAY_MODE);
  wire         wr_sel = wr_w & (avs_address_i == `PSTB_A_RSEL);
  wire         clr_w  = wr_w & (avs_address_i == `PSTB_A_CMD) & avs_byteenable_i[0]
                        & avs_writedata_i[`PSTB_CMD_CLR];
  assign avs_waitrequest_o = req_w & ~ack_reg;

  wire                   dtype_w = ctrl_reg[`PSTB_CTRL_DTYPE];
  wire                   drel_w  = ctrl_reg[`PSTB_CTRL_DREL];
  wire                   trst_w  = ctrl_reg[`PSTB_CTRL_TRST];
  wire                   cont_w  = ctrl_reg[`PSTB_CTRL_CONT];
  wire [5:0]             mask_w  = ctrl_reg[`PSTB_CTRL_MASK +: 6];
  wire [`PSTB_VAL_W-1:0] uset_w  = uset_reg[15:0];
  wire [`PSTB_VAL_W-1:0] ilim_w  = uset_reg[31:16];

  // pick-up with built-in 103 % release
  logic pick_reg, blk_s_reg, start_reg, trip_reg, blocked_reg;
  wire [31:0] meas_pct = 32'(meas_u3h_i) * `PSTB_PCT;
  wire [31:0] uset_hys = 32'(uset_w) * `PSTB_HYST_PCT;
  wire        pick_now = (meas_u3h_i < uset_w) | (pick_reg & (meas_pct < uset_hys)); // RULE_21
  wire        inh_w    = (ilim_w != 16'h0) & (ipos_i < ilim_w); // RULE_22

  // inverse time engine, refreshed each tick
  pstb_calc_e     calc_reg;
  logic [31:0]    num_reg, den_reg, rem_reg, x_reg, p_reg;
  logic [4:0]     bit_reg;
  logic [15:0]    pow_reg;
  logic [OPW-1:0] inverse_delay_mode_ticks_reg;
  wire  [63:0]    ds_w    = div_step(rem_reg, num_reg, den_reg);
  wire  [15:0]    a_int   = inverse_delay_mode_reg[31:16] / `PSTB_A_UNIT;
  wire  [15:0]    pow_n   = (a_int > `PSTB_A_MAX) ? `PSTB_A_MAX : a_int;
  wire  [31:0]    diff_w  = 32'((meas_u3h_i > uset_w) ? meas_u3h_i - uset_w : uset_w - meas_u3h_i);
  wire  [63:0]    prod_w  = {32'h0, p_reg} * {32'h0, x_reg};
  wire  [31:0]    psat_w  = (|prod_w[63:32+`PSTB_Q]) ? 32'hFFFF_FFFF : prod_w[31+`PSTB_Q:`PSTB_Q];
  wire  [31:0]    knum_w  = 32'(32'(inverse_delay_mode_reg[15:0]) * 32'(TPCS)) << `PSTB_Q;
  wire            qbig_w  = |ds_w[31:OPW];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      calc_reg       <= PSTB_C_IDLE;
      num_reg        <= 32'h0;
      den_reg        <= 32'h1;
      rem_reg        <= 32'h0;
      x_reg          <= 32'h0;
      p_reg          <= 32'h0;
      bit_reg        <= 5'h0;
      pow_reg        <= 16'h0;
      inverse_delay_mode_ticks_reg <= '1;
    end else begin
      case (calc_reg)
        PSTB_C_IDLE: begin
          if (tick_w && dtype_w) begin // RULE_07
            num_reg  <= diff_w << `PSTB_Q;
            den_reg  <= (uset_w == 16'h0) ? 32'h1 : 32'(uset_w);
            rem_reg  <= 32'h0;
            bit_reg  <= 5'h0;
            calc_reg <= PSTB_C_RATIO;
          end
        end
        PSTB_C_RATIO: begin
          {rem_reg, num_reg} <= ds_w;
          bit_reg            <= 5'(bit_reg + 5'h1);
          if (bit_reg == 5'h1F) begin
            x_reg    <= ds_w[31:0];
            p_reg    <= 32'h1 << `PSTB_Q;
            pow_reg  <= pow_n;
            calc_reg <= PSTB_C_POW;
          end
        end
        PSTB_C_POW: begin
          if (pow_reg == 16'h0) begin
            num_reg  <= knum_w;
            den_reg  <= (p_reg == 32'h0) ? 32'h1 : p_reg;
            rem_reg  <= 32'h0;
            bit_reg  <= 5'h0;
            calc_reg <= PSTB_C_TIME;
          end else begin
            p_reg   <= psat_w;
            pow_reg <= 16'(pow_reg - 16'h1);
          end
        end
        PSTB_C_TIME: begin
          {rem_reg, num_reg} <= ds_w;
          bit_reg            <= 5'(bit_reg + 5'h1);
          if (bit_reg == 5'h1F) begin
            inverse_delay_mode_ticks_reg <= qbig_w ? '1 : ds_w[OPW-1:0];
            calc_reg       <= PSTB_C_IDLE;
          end
        end
        default: calc_reg <= PSTB_C_IDLE;
      endcase
    end
  end

  // stage timing, evaluated only on ticks
  logic [OPW-1:0] op_reg, rel_cnt_reg;
  wire  [OPW-1:0] target_w  = dtype_w ? inverse_delay_mode_ticks_reg : dt_reg[OPW-1:0]; // RULE_08 RULE_09
  wire            pick_rise = pick_now & ~start_reg & ~blocked_reg;
  wire            blk_new   = pick_rise & blk_s_reg; // RULE_03
  wire            start_go  = pick_now & ~blocked_reg & ~blk_new; // RULE_02
  wire  [OPW-1:0] op_inc    = (&op_reg) ? op_reg : OPW'(op_reg + 1'b1);
  wire            rel_end   = (OPW'(rel_cnt_reg + 1'b1) >= rel_reg[OPW-1:0]);
  wire            releasing = ~pick_now & (start_reg | (op_reg != '0)) & ~trip_reg;
  wire            trip_due  = start_go & (op_inc >= target_w) & ~inh_w; // RULE_05 RULE_06 RULE_15
  // blocking is taken at the tick, so the source must lead a trip by one tick
  wire            blocked_n = blk_new | (pick_now & blocked_reg); // RULE_04
  wire            trip_n    = trip_due | (pick_now & trip_reg & ~blocked_reg);
  wire            start_n   = start_go | (~pick_now & ~trip_reg & drel_w & start_reg & ~rel_end); // RULE_11 RULE_12
  wire  [OPW-1:0] op_rel    = (~trst_w | rel_end) ? '0 : (cont_w ? op_inc : op_reg); // RULE_13 RULE_14
  wire  [OPW-1:0] op_n      = start_go ? op_inc : (releasing ? op_rel : '0);
  wire  [OPW-1:0] rel_n     = releasing ? OPW'(rel_cnt_reg + 1'b1) : '0;
  wire  [OPW-1:0] remain_w  = (target_w > op_n) ? OPW'(target_w - op_n) : '0;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0;
      pick_reg     <= 1'b0;
      blk_s_reg    <= 1'b0;
      start_reg    <= 1'b0;
      trip_reg     <= 1'b0;
      blocked_reg  <= 1'b0;
      op_reg       <= '0;
      rel_cnt_reg  <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next; // RULE_23
      if (tick_w) begin
        blk_s_reg   <= block_i; // RULE_01
        pick_reg    <= pick_now;
        start_reg   <= start_n;
        trip_reg    <= trip_n;
        blocked_reg <= blocked_n;
        op_reg      <= op_n;
        rel_cnt_reg <= rel_n;
      end
    end
  end
  assign start_o   = start_reg;
  assign trip_o    = trip_reg;
  assign blocked_o = blocked_reg;

  // edges of the three outputs
  wire [2:0] rise_w = {3{tick_w}} & {blocked_n & ~blocked_reg, trip_n & ~trip_reg, start_n & ~start_reg};
  wire [2:0] fall_w = {3{tick_w}} & {~blocked_n & blocked_reg, ~trip_n & trip_reg, ~start_n & start_reg};
  wire [5:0] ev_w   = {fall_w[2], rise_w[2], fall_w[1], rise_w[1], fall_w[0], rise_w[0]};

  // measurement history and snapshot taken at each tick
  logic [`PSTB_VAL_W-1:0] hist_mem [HDEPTH];
  logic [5:0]             hptr_reg;
  logic [`PSTB_VAL_W-1:0] snap_val_reg, snap_near_reg, snap_far_reg;
  logic [OPW-1:0]         snap_rem_reg;
  logic [2:0]             snap_grp_reg;
  logic [31:0]            snap_time_reg;
  wire  [5:0]             near_idx = (hptr_reg >= 6'(HNEAR)) ? 6'(hptr_reg - 6'(HNEAR))
                                     : 6'(hptr_reg + 6'(HDEPTH - HNEAR));
  wire  [5:0]             hptr_n   = (hptr_reg == 6'(HDEPTH - 1)) ? 6'h0 : 6'(hptr_reg + 6'h1);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hptr_reg <= 6'h0;
    end else if (tick_w) begin
      hptr_reg <= hptr_n;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (tick_w) begin
      hist_mem[hptr_reg] <= meas_u3h_i;
      snap_val_reg       <= meas_u3h_i; // RULE_20
      snap_near_reg      <= hist_mem[near_idx];
      snap_far_reg       <= hist_mem[hptr_reg];
      snap_rem_reg       <= remain_w;
      snap_grp_reg       <= setting_group_i;
      snap_time_reg      <= timestamp_i;
    end
  end

  // event stream, one per cycle, a new event wins over its own retirement
  logic [5:0] evp_reg;
  wire  [2:0] ev_idx  = low_idx(evp_reg);
  wire  [5:0] ev_done = (|evp_reg) ? (6'h1 << ev_idx) : 6'h0;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      evp_reg       <= 6'h0;
      event_valid_o <= 1'b0;
      event_code_o  <= PSTB_EV_START_ON;
      event_time_o  <= 32'h0;
    end else begin
      evp_reg       <= (evp_reg & ~ev_done) | (ev_w & mask_w); // RULE_16
      event_valid_o <= |evp_reg;
      event_code_o  <= pstb_evt_e'(ev_idx);
      event_time_o  <= snap_time_reg;
    end
  end

  // counters
  logic [15:0] cnt_st_reg, cnt_tr_reg, cnt_bl_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_st_reg <= 16'h0;
      cnt_tr_reg <= 16'h0;
      cnt_bl_reg <= 16'h0;
    end else begin
      cnt_st_reg <= cnt_upd(cnt_st_reg, rise_w[0], clr_w); // RULE_17
      cnt_tr_reg <= cnt_upd(cnt_tr_reg, rise_w[1], clr_w);
      cnt_bl_reg <= cnt_upd(cnt_bl_reg, rise_w[2], clr_w);
    end
  end

  // fault record ring
  logic [31:0]            rec_t_mem [`PSTB_REC_DEPTH];
  logic [7:0]             rec_e_mem [`PSTB_REC_DEPTH];
  logic [31:0]            rec_v_mem [`PSTB_REC_DEPTH];
  logic [`PSTB_VAL_W-1:0] rec_f_mem [`PSTB_REC_DEPTH];
  logic [OPW-1:0]         rec_r_mem [`PSTB_REC_DEPTH];
  logic [2:0]             rp_reg;
  logic [3:0]             rwp_reg, rcnt_reg;
  wire  [2:0]             rp_idx = low_idx({3'h0, rp_reg});
  wire                    rec_we = |rp_reg;
  wire  [3:0]             rsel_w = (rsel_reg[3:0] < 4'(`PSTB_REC_DEPTH)) ? rsel_reg[3:0] : 4'h0;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rp_reg   <= 3'h0;
      rwp_reg  <= 4'h0;
      rcnt_reg <= 4'h0;
    end else begin
      rp_reg <= (rp_reg & ~(rec_we ? 3'(3'h1 << rp_idx) : 3'h0)) | rise_w; // RULE_19
      if (rec_we) begin
        rwp_reg  <= (rwp_reg == 4'(`PSTB_REC_DEPTH - 1)) ? 4'h0 : 4'(rwp_reg + 4'h1); // RULE_18
        rcnt_reg <= (rcnt_reg == 4'(`PSTB_REC_DEPTH)) ? rcnt_reg : 4'(rcnt_reg + 4'h1);
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rec_we) begin
      rec_t_mem[rwp_reg] <= snap_time_reg; // RULE_20
      rec_e_mem[rwp_reg] <= {1'b0, snap_grp_reg, 1'b0, rp_idx[1:0], 1'b0};
      rec_v_mem[rwp_reg] <= {snap_near_reg, snap_val_reg};
      rec_f_mem[rwp_reg] <= snap_far_reg;
      rec_r_mem[rwp_reg] <= snap_rem_reg;
    end
  end

  // register write and read path
  wire [31:0] stat_w = {remain_w, 3'h0, blk_s_reg, pick_reg, blocked_reg, trip_reg, start_reg};
  wire [31:0] rd_mux =
    (avs_address_i == `PSTB_A_CTRL)   ? ctrl_reg :
    (avs_address_i == `PSTB_A_USET)   ? uset_reg :
    (avs_address_i == `PSTB_A_DT)     ? dt_reg :
    (avs_address_i == `PSTB_A_REL)    ? rel_reg :
    (avs_address_i == `PSTB_A_INVERSE_DELAY_MODE)   ? inverse_delay_mode_reg :
    (avs_address_i == `PSTB_A_STAT)   ? stat_w :
    (avs_address_i == `PSTB_A_CNT_ST) ? 32'(cnt_st_reg) :
    (avs_address_i == `PSTB_A_CNT_TR) ? 32'(cnt_tr_reg) :
    (avs_address_i == `PSTB_A_CNT_BL) ? 32'(cnt_bl_reg) :
    (avs_address_i == `PSTB_A_RSEL)   ? rsel_reg :
    (avs_address_i == `PSTB_A_REC_T)  ? rec_t_mem[rsel_w] :
    (avs_address_i == `PSTB_A_REC_E)  ? 32'(rec_e_mem[rsel_w]) :
    (avs_address_i == `PSTB_A_REC_V)  ? rec_v_mem[rsel_w] :
    (avs_address_i == `PSTB_A_REC_F)  ? 32'(rec_f_mem[rsel_w]) :
    (avs_address_i == `PSTB_A_REC_R)  ? 32'(rec_r_mem[rsel_w]) :
    (avs_address_i == `PSTB_A_REC_P)  ? {20'h0, rcnt_reg, 4'h0, rwp_reg} : 32'h0;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h0;
      ctrl_reg       <= `PSTB_RST_CTRL;
      uset_reg       <= `PSTB_RST_USET;
      dt_reg         <= `PSTB_RST_DT;
      rel_reg        <= `PSTB_RST_REL;
      inverse_delay_mode_reg       <= `PSTB_RST_INVERSE_DELAY_MODE;
      rsel_reg       <= 32'h0;
    end else begin
      ack_reg        <= req_w & ~ack_reg;
      avs_readdata_o <= (avs_read_i & ~ack_reg) ? rd_mux : avs_readdata_o;
      ctrl_reg       <= wr_ctl ? be_merge(ctrl_reg, avs_writedata_i, avs_byteenable_i) : ctrl_reg;
      uset_reg       <= wr_us ? be_merge(uset_reg, avs_writedata_i, avs_byteenable_i) : uset_reg;
      dt_reg         <= wr_dt ? be_merge(dt_reg, avs_writedata_i, avs_byteenable_i) : dt_reg;
      rel_reg        <= wr_rel ? be_merge(rel_reg, avs_writedata_i, avs_byteenable_i) : rel_reg;
      inverse_delay_mode_reg       <= wr_id ? be_merge(inverse_delay_mode_reg, avs_writedata_i, avs_byteenable_i) : inverse_delay_mode_reg; // RULE_10
      rsel_reg       <= wr_sel ? be_merge(rsel_reg, avs_writedata_i, avs_byteenable_i) : rsel_reg;
    end
  end

  // checks
  block_sample_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_01
    tick_w |=> (blk_s_reg == $past(block_i))) else $error("blocking input not sampled at tick");
  trip_needs_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_02
    trip_reg |-> start_reg) else $error("trip without start");
  blocked_no_trip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_03
    $rose(blocked_reg) |-> (!start_reg && !trip_reg)) else $error("blocked stage is timing");
  instant_trip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_05
    (tick_w && start_go && !start_reg && !dtype_w && dt_reg == 32'h0 && !inh_w) |=> trip_reg)
    else $error("instant mode did not trip with start");
  fast_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_12
    (tick_w && !pick_now && !drel_w) |=> !start_reg) else $error("start held without delayed release");
  release_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_11
    (tick_w && start_reg && !trip_reg && !pick_now && drel_w && rel_cnt_reg == '0 && rel_reg > 32'h1)
    |=> start_reg) else $error("start dropped at start of release");
  no_release_trip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_15
    (tick_w && !pick_now && !trip_reg) |=> !trip_reg) else $error("trip during release");
  inhibit_trip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_22
    (tick_w && inh_w && !trip_reg) |=> !trip_reg) else $error("trip under low current");
  cnt_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_17
    (clr_w && !rise_w[0]) |=> (cnt_st_reg == 16'h0)) else $error("start counter not cleared");
  rec_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_19
    rise_w[1] |-> ##[1:3] rec_we) else $error("trip edge left no record");
  event_emit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE_16
    (rise_w[0] && mask_w[0]) |-> ##2 (event_valid_o && event_code_o == PSTB_EV_START_ON))
    else $error("start on event missing");
  bus_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (req_w && avs_waitrequest_o) |=> !avs_waitrequest_o) else $error("bus held more than one wait");
endmodule

// ### test/pstb_matrix_model.sv
`timescale 1ns/10ps
// stand-in for the blocking matrix and measurement front end
module pstb_matrix_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        fault_i,
  input  wire logic        blk_i,
  output logic             block_o,
  output logic [15:0]      meas_o,
  output logic [15:0]      ipos_o,
  output logic [2:0]       grp_o,
  output logic [31:0]      ts_o
);
  // block follows one cycle after the request, far ahead of any trip
  always_ff @(posedge clk_sys_i) begin
    block_o <= rst_i ? 1'b0 : blk_i;
    ts_o    <= rst_i ? 32'h0 : ts_o + 32'h1;
  end
  // healthy level sits well above the release point
  assign meas_o = fault_i ? 16'h03E8 : 16'h1388;
  assign ipos_o = 16'h03E8;
  assign grp_o  = 3'h2;
endmodule

// ### test/protection_stage_timing_blocking_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module protection_stage_timing_blocking_test;
  import pstb_pkg::*;
  localparam int TICK = 40;
  localparam logic [7:0]  RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h80};
  localparam logic [31:0] RV [6] = '{32'h0000_03F6, 32'h0000_07D0, 32'h0000_0008,
                                     32'h0000_000C, 32'h0064_0005, 32'h0000_0000};
  localparam logic [7:0]  CA [3] = '{8'h18, 8'h1C, 8'h20};
  localparam logic [31:0] CV [3] = '{32'h2, 32'h2, 32'h1};
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rdat;
  logic        wreq;
  logic        fault = 1'b0;
  logic        blk = 1'b0;
  logic        block;
  logic [15:0] meas;
  logic [15:0] ipos;
  logic [2:0]  grp;
  logic [31:0] ts;
  logic        start_o;
  logic        trip_o;
  logic        blocked_o;
  logic        ev_v;
  pstb_evt_e   ev_c;
  pstb_evt_e   evq[$];
  logic [31:0] evt;
  logic [31:0] etq[$];
  int          num_errors = 0;
  int          comparisons = 0;
  int          n;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (ev_v === 1'b1) begin
      evq.push_back(ev_c);
      etq.push_back(evt);
    end
  end
  pstb_matrix_model pstb_matrix_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fault_i(fault),
    .blk_i(blk), .block_o(block), .meas_o(meas), .ipos_o(ipos), .grp_o(grp), .ts_o(ts));
  pstb_stage #(.TICK_CYCLES(TICK)) pstb_stage_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .block_i(block), .meas_u3h_i(meas), .ipos_i(ipos), .setting_group_i(grp), .timestamp_i(ts),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .event_valid_o(ev_v),
    .event_code_o(ev_c), .event_time_o(evt));
  function automatic logic sig_of(input int s);
    sig_of = (s == 0) ? start_o : (s == 1) ? trip_o : blocked_o;
  endfunction
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wd  <= d;
    rd  <= ~w;
    wr  <= w;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wreq !== 1'b0 && k < 100);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 100) num_errors++;
  endtask
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while (sig_of(s) !== v && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 2000) num_errors++;
  endtask
  task automatic final_report;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, RA[i], 32'h0);
      `CHK(rdat, RV[i])
    end
    $display("test defaults done");
    bus(1'b1, 8'h08, 32'h3);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    `CHK(n, 2 * TICK)
    fault <= 1'b0;
    wait_for(0, 1'b0);
    `CHK(evq[0], PSTB_EV_START_ON)
    `CHK(evq[1], PSTB_EV_TRIP_ON)
    $display("test fixed delay done");
    bus(1'b1, 8'h08, 32'h0);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    `CHK(trip_o, 1'b1)
    fault <= 1'b0;
    wait_for(0, 1'b0);
    $display("test instant done");
    blk <= 1'b1;
    repeat (2 * TICK) @(posedge clk_sys_i);
    fault <= 1'b1;
    wait_for(2, 1'b1);
    `CHK({start_o, trip_o}, 2'b00)
    fault <= 1'b0;
    blk <= 1'b0;
    wait_for(2, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, CA[i], 32'h0);
      `CHK(rdat, CV[i])
    end
    bus(1'b1, 8'h24, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, CA[i], 32'h0);
      `CHK(rdat, 32'h0)
    end
    $display("test blocking done");
    // ring so far: fixed start, fixed trip, instant start, instant trip, blocked
    bus(1'b1, 8'h28, 32'h3);
    bus(1'b0, 8'h30, 32'h0);
    `CHK(rdat, 32'h0000_0022)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rdat, 32'h0000_0505)
    bus(1'b1, 8'h28, 32'h4);
    bus(1'b0, 8'h34, 32'h0);
    `CHK(rdat[15:0], 16'h03E8)
    bus(1'b1, 8'h28, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    `CHK(rdat, 32'h2)
    bus(1'b0, 8'h2C, 32'h0);
    `CHK(rdat, etq[0])
    `CHK(rdat % TICK, TICK - 1)
    $display("test records done");
    // long delay so the pick-up ends before any trip
    bus(1'b1, 8'h08, 32'h64);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    fault <= 1'b0;
    repeat (10 * TICK) @(posedge clk_sys_i);
    `CHK(start_o, 1'b1)
    wait_for(0, 1'b0);
    `CHK(n <= 4 * TICK, 1'b1)
    `CHK(trip_o, 1'b0)
    bus(1'b1, 8'h00, 32'h0000_03F4);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    fault <= 1'b0;
    wait_for(0, 1'b0);
    `CHK(n <= 2 * TICK, 1'b1)
    $display("test release done");
    // 0.05 s over (0.5)^1 is 20 ticks; the timer resumes from the tick kept in release
    bus(1'b1, 8'h00, 32'h0000_03F5);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    `CHK(n, 18 * TICK)
    fault <= 1'b0;
    wait_for(0, 1'b0);
    $display("test inverse done");
    bus(1'b1, 8'h00, 32'h0000_03F4);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, 32'h07D0_07D0);
    fault <= 1'b1;
    wait_for(0, 1'b1);
    `CHK(trip_o, 1'b0)
    fault <= 1'b0;
    wait_for(0, 1'b0);
    $display("test inhibit done");
    final_report;
  end
endmodule
